// ===== nsq_pkg.sv
/*
 * Shared constants and types for the requantizer control block: register
 * offsets and fields, reset values, band mode codes, scaling figures and the
 * sample and configuration carriers.
 * Assumes a byte-wide register map reached over the three-wire serial port.
 */
package nsq_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NCH = 4;                       // Converter channels.
    localparam int SW  = 11;                      // Output sample width.

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CHSEL = 8'h05;    // Channel select.
    localparam logic [7:0] ADDR_CTRL  = 8'h3C;    // requantizer_control.
    localparam logic [7:0] ADDR_TUNE  = 8'h3E;    // band_tuning.
    localparam logic [7:0] ADDR_XFER  = 8'hFF;    // Shadow transfer.
    localparam int         CTRL_EN_BIT   = 0;     // Register enable.
    localparam int         CTRL_MODE_LSB = 1;     // Bandwidth mode, three bits.
    localparam int         CTRL_OVR_BIT  = 4;     // Ignore the mode pin.
    localparam logic [7:0] CTRL_MASK  = 8'h1F;
    localparam logic [7:0] TUNE_MASK  = 8'h3F;
    localparam int         XFER_BIT   = 0;
    localparam logic [3:0] CHSEL_RST  = 4'hF;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] TUNE_RST   = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // ------------------------------------------------------------------
    // Band modes and band geometry in steps of 0.005 of the sample rate
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BW_NARROW = 3'b000,
        BW_MIDDLE = 3'b001,
        BW_WIDE   = 3'b010
    } nsq_bw_t;
    localparam logic [6:0] HALF_NARROW  = 7'h16;  // 0.11 of the rate.
    localparam logic [6:0] HALF_MIDDLE  = 7'h21;  // 0.165 of the rate.
    localparam logic [6:0] HALF_WIDE    = 7'h24;  // 0.18 of the rate.
    localparam logic [6:0] WORDS_NARROW = 7'h39;  // 57 tuning words.
    localparam logic [6:0] WORDS_MIDDLE = 7'h22;  // 34 tuning words.
    localparam logic [6:0] WORDS_WIDE   = 7'h1C;  // 28 tuning words.
    localparam logic [6:0] QUARTER_RATE = 7'h32;  // One quarter of the rate.
    localparam logic [6:0] ONE_WORD     = 7'h01;

    // ------------------------------------------------------------------
    // Fixed 0.6 dB loss: gain 239/256
    // ------------------------------------------------------------------
    localparam logic signed [19:0] ATT_NUM   = 20'sh000EF;
    localparam int                 ATT_SHIFT = 8;
    localparam logic signed [10:0] FS_IN     = 11'sh3FF;
    localparam logic signed [10:0] FS_ATT_LO = 11'sh3BA;
    localparam logic signed [10:0] FS_ATT_HI = 11'sh3BC;

    // ------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [2:0] BYTE_LAST  = 3'h7;
    localparam int         RD_FLAG    = 15;
    typedef enum logic [1:0] {
        SP_INSTR = 2'b00,
        SP_WRITE = 2'b01,
        SP_READ  = 2'b10
    } nsq_spi_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                 valid;
        logic signed [SW-1:0] data;
    } nsq_sample_t;

    typedef struct packed {
        logic       enable;
        nsq_bw_t    bw;
        logic [5:0] tune;
    } nsq_cfg_t;

endpackage

// ===== nsq_channel.sv
/*
 * One channel of the noise shaping requantizer: fixed loss, first order
 * error feedback whose sign follows the tuned band, and a bypass path.
 * Assumes samples arrive on clk with a valid flag and a stable config.
 */
`timescale 1ns/100ps
module nsq_channel (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // Active configuration.
    input  wire nsq_pkg::nsq_cfg_t    cfg,
    // Sample stream.
    input  wire nsq_pkg::nsq_sample_t sampleIn,
    output nsq_pkg::nsq_sample_t      sampleOut
);
    import nsq_pkg::*;

    logic        [6:0]  halfWidth;
    logic        [6:0]  wordCount;
    logic        [6:0]  tuneEff;
    logic        [6:0]  bandCentre;
    logic               noiseHigh;
    logic signed [19:0] scaled;
    logic signed [19:0] shaped;
    logic        [7:0]  err_r;
    nsq_sample_t        out_r;

    // ------------------------------------------------------------------
    // Band geometry
    // ------------------------------------------------------------------
    // Half width and word count of the chosen mode; undefined codes fall
    // back to the narrow mode.
    always_comb begin
        case (cfg.bw)
            BW_NARROW: begin
                halfWidth = HALF_NARROW; // RL3
                wordCount = WORDS_NARROW;
            end
            BW_MIDDLE: begin
                halfWidth = HALF_MIDDLE; // RL4
                wordCount = WORDS_MIDDLE;
            end
            BW_WIDE: begin
                halfWidth = HALF_WIDE; // RL5
                wordCount = WORDS_WIDE;
            end
            default: begin
                halfWidth = HALF_NARROW;
                wordCount = WORDS_NARROW;
            end
        endcase
    end

    // Left edge is the word in half percent steps; an oversized word is
    // held at the last legal one so the centre stays inside the band.
    assign tuneEff    = ({1'b0, cfg.tune} >= wordCount) ? wordCount - ONE_WORD
                                                        : {1'b0, cfg.tune}; // RL7
    assign bandCentre = tuneEff + halfWidth; // RL6
    assign noiseHigh  = bandCentre < QUARTER_RATE;

    // ------------------------------------------------------------------
    // Requantizer arithmetic
    // ------------------------------------------------------------------
    // Scale by 239/256 and feed back the residue: adding it pushes the
    // noise up, subtracting it pushes the noise down, away from the band.
    assign scaled = 20'(sampleIn.data) * ATT_NUM; // RL1
    assign shaped = noiseHigh ? scaled + $signed({12'h000, err_r})
                              : scaled - $signed({12'h000, err_r});

    // Output register; both paths have one cycle of latency.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_r <= '0;
            err_r <= '0;
        end else begin
            out_r.valid <= sampleIn.valid;
            if (sampleIn.valid) begin
                if (cfg.enable) begin
                    out_r.data <= shaped[ATT_SHIFT+SW-1:ATT_SHIFT]; // RL1
                    err_r      <= shaped[ATT_SHIFT-1:0];
                end else begin
                    out_r.data <= sampleIn.data; // RL15
                    err_r      <= '0;
                end
            end
        end
    end

    assign sampleOut = out_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    bypass_path_a: assert property ( // RL15
        @(posedge clk) disable iff (!resetn)
        (sampleIn.valid && !cfg.enable) |=> (sampleOut.data == $past(sampleIn.data)))
        else $error("Disabled channel altered its sample.");

    full_scale_loss_a: assert property ( // RL1
        @(posedge clk) disable iff (!resetn)
        (sampleIn.valid && cfg.enable && sampleIn.data == FS_IN)
            |=> (sampleOut.data >= FS_ATT_LO && sampleOut.data <= FS_ATT_HI))
        else $error("Full scale input not reduced by the fixed loss.");

endmodule

// ===== nsq_ctrl.sv
/*
 * Requantizer control for four converter channels: serial register port,
 * per channel shadow and active settings, mode pin handling and the four
 * requantizer channels.
 * Assumes serial port and mode pin are asynchronous to clk and that the
 * serial clock is well below a quarter of clk.
 */
// How it works
// RL1: An enabled channel loses 0.6 dB, full scale appears at -0.6 dBFS.
// RL2: Each channel is enabled separately, by register or by mode pin.
// RL3: Mode code 000 picks narrow band, 0.22 wide, 57 words.
// RL4: Mode code 001 picks middle band, 0.33 wide, 34 words.
// RL5: Mode code 010 picks wide band, 0.36 wide, 28 words.
// RL6: A 6-bit word in the tuning register sets band position.
// RL7: Left edge sits at 0.005 times rate times tuning word.
// RL8: Band width comes only from registers, never from the mode pin.
// RL9: Mode pin low enables, high gives plain 11-bit samples.
// RL10: Mode pin reads high when open, so requantizer stays off.
// RL11: Control bit 4 makes a channel ignore the pin, register only.
// RL12: Writes sit in shadows until 0x01 to the transfer address.
// RL13: Writes reach every selected channel; host selects channels first.
// RL14: A read with several channels selected returns channel A.
// RL15: Disabled channels pass samples unchanged with equal latency.
// RL16: Host keeps tuning words below the mode's word count.
`timescale 1ns/100ps
module nsq_ctrl (
    // Clock and reset.
    input  wire logic                                    clk,
    input  wire logic                                    resetn,
    // Mode pin, asynchronous.
    input  wire logic                                    modePin,
    // Serial port pins, asynchronous.
    input  wire logic                                    sclkPin,
    input  wire logic                                    csbPin_n,
    input  wire logic                                    sdioIn,
    output logic                                         sdioOut,
    output logic                                         sdioOen_n,
    // Sample streams.
    input  wire nsq_pkg::nsq_sample_t [nsq_pkg::NCH-1:0] sampleIn,
    output nsq_pkg::nsq_sample_t      [nsq_pkg::NCH-1:0] sampleOut,
    // Status.
    output logic                      [nsq_pkg::NCH-1:0] chanActive
);
    import nsq_pkg::*;

    logic                      modeS1_r, modeS2_r;
    logic                      sclkS1_r, sclkS2_r, sclkD_r;
    logic                      csbS1_r, csbS2_r;
    logic                      sdS1_r, sdS2_r;
    logic                      sclkRise, sclkFall;
    nsq_spi_t                  phase_r;
    logic [3:0]                bitCnt_r;
    logic [15:0]               shift_r;
    logic [15:0]               instrWord;
    logic [12:0]               addr_r;
    logic [7:0]                readShift_r;
    logic [7:0]                wrByte;
    logic                      wrStrobe;
    logic                      xferPulse;
    logic                      instrDone;
    logic [3:0]                chanSel_r;
    logic [NCH-1:0][7:0]       ctrlShd_r, ctrlAct_r, tuneShd_r, tuneAct_r;
    logic [NCH-1:0]            chanEn;
    logic [NCH-1:0]            chanActive_r;
    logic                      sdioOut_r, sdioOenN_r;
    nsq_cfg_t [NCH-1:0]        cfg;

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    // Two flops on every pin; the mode pin resets high like its pull-up,
    // and the serial clock resets to its idle high level, so no false edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            modeS1_r <= 1'b1; // RL10
            modeS2_r <= 1'b1;
            sclkS1_r <= 1'b1;
            sclkS2_r <= 1'b1;
            sclkD_r  <= 1'b1;
            csbS1_r  <= 1'b1;
            csbS2_r  <= 1'b1;
            sdS1_r   <= 1'b0;
            sdS2_r   <= 1'b0;
        end else begin
            modeS1_r <= modePin;
            modeS2_r <= modeS1_r;
            sclkS1_r <= sclkPin;
            sclkS2_r <= sclkS1_r;
            sclkD_r  <= sclkS2_r;
            csbS1_r  <= csbPin_n;
            csbS2_r  <= csbS1_r;
            sdS1_r   <= sdioIn;
            sdS2_r   <= sdS1_r;
        end
    end

    assign sclkRise  = sclkS2_r && !sclkD_r && !csbS2_r;
    assign sclkFall  = !sclkS2_r && sclkD_r && !csbS2_r;
    assign instrWord = {shift_r[14:0], sdS2_r};
    assign instrDone = sclkRise && phase_r == SP_INSTR && bitCnt_r == INSTR_LAST;
    assign wrByte    = {shift_r[6:0], sdS2_r};
    assign wrStrobe  = sclkRise && phase_r == SP_WRITE && bitCnt_r[2:0] == BYTE_LAST;
    assign xferPulse = wrStrobe && addr_r == {5'h00, ADDR_XFER} && wrByte[XFER_BIT];

    // Read value: per channel registers answer with channel A only.
    function automatic logic [7:0] readReg(input logic [12:0] a);
        logic [7:0] v;
        v = READ_ZERO;
        if (a == {5'h00, ADDR_CHSEL}) v = {4'h0, chanSel_r};
        if (a == {5'h00, ADDR_CTRL})  v = ctrlShd_r[0]; // RL14
        if (a == {5'h00, ADDR_TUNE})  v = tuneShd_r[0]; // RL14
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Serial frame sequencer
    // ------------------------------------------------------------------
    // Sixteen instruction bits, then bytes until chip select rises; the
    // address steps down after each byte, as in MSB first streaming.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r     <= SP_INSTR;
            bitCnt_r    <= '0;
            shift_r     <= '0;
            addr_r      <= '0;
            readShift_r <= '0;
        end else if (csbS2_r) begin
            phase_r  <= SP_INSTR;
            bitCnt_r <= '0;
        end else if (sclkRise) begin
            shift_r  <= instrWord;
            bitCnt_r <= bitCnt_r + 4'h1;
            case (phase_r)
                SP_INSTR: begin
                    if (instrDone) begin
                        bitCnt_r    <= '0;
                        addr_r      <= instrWord[12:0];
                        readShift_r <= readReg(instrWord[12:0]);
                        phase_r     <= instrWord[RD_FLAG] ? SP_READ : SP_WRITE;
                    end
                end
                SP_WRITE: begin
                    if (wrStrobe) begin
                        bitCnt_r <= '0;
                        addr_r   <= addr_r - 13'h0001;
                    end
                end
                SP_READ: begin
                    if (bitCnt_r[2:0] == BYTE_LAST) begin
                        bitCnt_r    <= '0;
                        addr_r      <= addr_r - 13'h0001;
                        readShift_r <= readReg(addr_r - 13'h0001);
                    end
                end
                default: phase_r <= SP_INSTR;
            endcase
        end else if (sclkFall && phase_r == SP_READ) begin
            readShift_r <= {readShift_r[6:0], 1'b0};
        end
    end

    // Data pin driver: drives on falling serial clock during a read.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sdioOut_r  <= 1'b0;
            sdioOenN_r <= 1'b1;
        end else if (csbS2_r || phase_r != SP_READ) begin
            sdioOenN_r <= 1'b1;
        end else if (sclkFall) begin
            sdioOut_r  <= readShift_r[7];
            sdioOenN_r <= 1'b0;
        end
    end

    assign sdioOut   = sdioOut_r;
    assign sdioOen_n = sdioOenN_r;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Channel select register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chanSel_r <= CHSEL_RST;
        end else if (wrStrobe && addr_r == {5'h00, ADDR_CHSEL}) begin
            chanSel_r <= wrByte[3:0];
        end
    end

    // Shadow copies take writes for every selected channel.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrlShd_r <= {NCH{CTRL_RST}};
            tuneShd_r <= {NCH{TUNE_RST}};
        end else if (wrStrobe) begin
            for (int i = 0; i < NCH; i++) begin
                if (chanSel_r[i] && addr_r == {5'h00, ADDR_CTRL}) begin
                    ctrlShd_r[i] <= wrByte & CTRL_MASK; // RL13
                end
                if (chanSel_r[i] && addr_r == {5'h00, ADDR_TUNE}) begin
                    tuneShd_r[i] <= wrByte & TUNE_MASK; // RL13
                end
            end
        end
    end

    // Transfer copies all shadows at once; the transfer bit is a pulse.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrlAct_r <= {NCH{CTRL_RST}};
            tuneAct_r <= {NCH{TUNE_RST}};
        end else if (xferPulse) begin
            ctrlAct_r <= ctrlShd_r; // RL12
            tuneAct_r <= tuneShd_r; // RL12
        end
    end

    // ------------------------------------------------------------------
    // Channel enables and datapath
    // ------------------------------------------------------------------
    // Override bit selects register control; otherwise the pin, active low.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            chanEn[i] = ctrlAct_r[i][CTRL_OVR_BIT] ? ctrlAct_r[i][CTRL_EN_BIT] // RL11
                                                   : !modeS2_r; // RL9
            cfg[i].enable = chanEn[i]; // RL2
            cfg[i].bw     = nsq_bw_t'(ctrlAct_r[i][CTRL_MODE_LSB +: 3]); // RL8
            cfg[i].tune   = tuneAct_r[i][5:0]; // RL6
        end
    end

    // Status register of the enables in use.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chanActive_r <= '0;
        end else begin
            chanActive_r <= chanEn;
        end
    end

    assign chanActive = chanActive_r;

    // One requantizer per channel.
    for (genvar g = 0; g < NCH; g++) begin : gChan
        nsq_channel uChan (
            .clk       (clk),
            .resetn    (resetn),
            .cfg       (cfg[g]),
            .sampleIn  (sampleIn[g]),
            .sampleOut (sampleOut[g])
        );
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    xfer_apply_a: assert property ( // RL12
        @(posedge clk) disable iff (!resetn)
        xferPulse |=> (ctrlAct_r == $past(ctrlShd_r) && tuneAct_r == $past(tuneShd_r)))
        else $error("Transfer did not copy shadows.");

    shadow_hold_a: assert property ( // RL12
        @(posedge clk) disable iff (!resetn)
        !xferPulse |=> ($stable(ctrlAct_r) && $stable(tuneAct_r)))
        else $error("Active settings moved without transfer.");

    select_write_a: assert property ( // RL13
        @(posedge clk) disable iff (!resetn)
        (wrStrobe && addr_r == {5'h00, ADDR_TUNE} && chanSel_r[2])
            |=> (tuneShd_r[2] == ($past(wrByte) & TUNE_MASK)))
        else $error("Selected channel missed a tuning write.");

    unselected_keep_a: assert property ( // RL13
        @(posedge clk) disable iff (!resetn)
        (wrStrobe && !chanSel_r[1]) |=> $stable(ctrlShd_r[1]))
        else $error("Unselected channel took a write.");

    read_first_a: assert property ( // RL14
        @(posedge clk) disable iff (!resetn)
        (instrDone && instrWord[RD_FLAG] && instrWord[12:0] == {5'h00, ADDR_CTRL})
            |=> (readShift_r == $past(ctrlShd_r[0])))
        else $error("Read did not return channel A.");

    pin_enable_a: assert property ( // RL9
        @(posedge clk) disable iff (!resetn)
        !ctrlAct_r[3][CTRL_OVR_BIT] |-> (chanEn[3] == !modeS2_r))
        else $error("Pin did not steer the channel enable.");

    override_a: assert property ( // RL11
        @(posedge clk) disable iff (!resetn)
        ctrlAct_r[0][CTRL_OVR_BIT] |-> (chanEn[0] == ctrlAct_r[0][CTRL_EN_BIT]))
        else $error("Override channel followed the pin.");

    pin_no_width_a: assert property ( // RL8
        @(posedge clk) disable iff (!resetn)
        (!$past(xferPulse) && $changed(modeS2_r)) |-> $stable(cfg[1].bw))
        else $error("Mode pin changed the band width.");

endmodule

// ===== nsq_host_model.sv
/*
 * Serial configuration host model: frames on the three-wire port.
 * Assumes clk is the device clock; sdio level is resolved here.
 */
`timescale 1ns/100ps
module nsq_host_model (
    // Clock.
    input  wire logic clk,
    // Serial pins.
    output logic      sclkPin,
    output logic      csbPin_n,
    output logic      sdioIn,
    input  wire logic sdioOut,
    input  wire logic sdioOen_n
);
    logic hostD, hostOe, lastD;
    // Wire level: device when it drives, else host, else a released line flips.
    assign sdioIn = !sdioOen_n ? sdioOut : (hostOe ? hostD : ~lastD);
    // Idle pins.
    initial begin
        sclkPin = 1'b1;
        csbPin_n = 1'b1;
        hostD = 1'b0;
        hostOe = 1'b1;
    end
    // Remember the last driven bit.
    always @(posedge clk) if (hostOe) lastD <= hostD;
    // One bit: five clocks low, then five high; read bits taken before the rise.
    task automatic bitCycle(input logic b, output logic q);
        @(posedge clk);
        sclkPin <= 1'b0;
        hostD <= b;
        repeat (5) @(posedge clk);
        q = sdioIn;
        sclkPin <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // One frame: instruction, address, one data byte.
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                        output logic [7:0] rv);
        logic [23:0] f;
        logic        q;
        f = {rd, 2'b00, a, wd};
        @(posedge clk);
        csbPin_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            hostOe <= !(rd && i < 8);
            bitCycle(f[i], q);
            rv[i % 8] = q;
        end
        csbPin_n <= 1'b1;
        hostOe <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ===== test_nsq_ctrl.sv
/*
 * Self-checking bench for the requantizer control block.
 * Assumes nsq_pkg and nsq_host_model are compiled first.
 */
`timescale 1ns/100ps
module test_nsq_ctrl;
    import nsq_pkg::*;
    logic                  clk, resetn, modePin;
    logic                  sclkPin, csbPin_n, sdioIn, sdioOut, sdioOen_n;
    nsq_sample_t [NCH-1:0] sampleIn, sampleOut;
    logic [NCH-1:0]        chanActive;
    logic [16:0]           lfsr;
    logic [14:0]           noteQ[$];
    logic [7:0]            rv, tw;
    logic [6:0]            words [3];
    int                    errCount, checks;

    nsq_ctrl uut (.clk, .resetn, .modePin, .sclkPin, .csbPin_n, .sdioIn, .sdioOut,
                  .sdioOen_n, .sampleIn, .sampleOut, .chanActive);
    nsq_host_model host (.clk, .sclkPin, .csbPin_n, .sdioIn, .sdioOut, .sdioOen_n);

    // Clock of 50 ns.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic checkByte(input logic [7:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %0t %s got %h", $time, m, got);
        end
    endtask
    task automatic checkSample(input logic signed [10:0] got, input int lo, hi);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errCount++;
            $display("CHECK FAILED %0t sample %0d", $time, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        host.xfer(1'b0, {5'h00, a}, d, rv);
    endtask
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b1, {5'h00, a}, 8'h00, rv);
    endtask
    // Next state of the 17-bit stimulus register.
    function automatic logic [16:0] lfsrStep(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic settle;
        repeat (8) @(posedge clk);
    endtask
    // Back-to-back samples, full scale first; a note records the enable mask.
    task automatic sendSamples(input logic [3:0] mask, input int n);
        logic signed [10:0] x;
        for (int k = 0; k < n; k++) begin
            lfsr = lfsrStep(lfsr);
            x = (k == 0) ? FS_IN : lfsr[10:0];
            @(posedge clk);
            sampleIn <= {NCH{nsq_sample_t'({1'b1, x})}};
            noteQ.push_back({mask, x});
        end
        @(posedge clk);
        sampleIn <= '0;
    endtask
    // Each valid output takes the oldest note and checks every channel.
    always @(negedge clk) begin
        logic [14:0] n;
        int          p;
        if (resetn === 1'b1 && sampleOut[0].valid === 1'b1) begin
            checkByte(8'(noteQ.size() != 0), 8'h01, "sample note");
            n = (noteQ.size() > 0) ? noteQ.pop_front() : '1;
            p = int'(ATT_NUM) * $signed(n[10:0]);
            for (int i = 0; i < NCH; i++) begin
                if (n[11+i])
                    checkSample(sampleOut[i].data, (p - 255) >>> 8, (p + 255) >>> 8);
                else
                    checkSample(sampleOut[i].data, $signed(n[10:0]), $signed(n[10:0]));
            end
        end
    end
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog well beyond the expected run.
    initial begin
        repeat (40000) @(posedge clk);
        errCount++;
        final_report();
    end
    // Main sequence.
    initial begin
        resetn = 1'b0;
        modePin = 1'b1;
        sampleIn = '0;
        lfsr = 17'd95197;
        words = '{WORDS_NARROW, WORDS_MIDDLE, WORDS_WIDE};
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        settle();
        rd(ADDR_CTRL);
        checkByte(rv, CTRL_RST, "ctrl reset");
        rd(ADDR_TUNE);
        checkByte(rv, TUNE_RST, "tune reset");
        rd(8'h30);
        checkByte(rv, READ_ZERO, "unmapped");
        checkByte(8'(chanActive), 8'h00, "pin high");
        sendSamples(4'h0, 4);
        modePin <= 1'b0;
        settle();
        checkByte(8'(chanActive), 8'h0F, "pin low");
        sendSamples(4'hF, 4);
        wr(ADDR_CHSEL, 8'h06);
        wr(ADDR_CTRL, 8'h10);
        checkByte(8'(chanActive), 8'h0F, "shadow held");
        wr(ADDR_XFER, 8'h01);
        checkByte(8'(chanActive), 8'h09, "override off");
        sendSamples(4'h9, 3);
        modePin <= 1'b1;
        wr(ADDR_CHSEL, 8'h04);
        wr(ADDR_CTRL, 8'h11);
        wr(ADDR_XFER, 8'h01);
        checkByte(8'(chanActive), 8'h04, "override on");
        sendSamples(4'h4, 3);
        wr(ADDR_CHSEL, 8'h01);
        wr(ADDR_CTRL, 8'h03);
        wr(ADDR_CHSEL, 8'h0F);
        rd(ADDR_CTRL);
        checkByte(rv, 8'h03, "multi read");
        rd(ADDR_XFER);
        checkByte(rv, 8'h00, "xfer clear");
        for (int m = 0; m < 3; m++) begin
            lfsr = lfsrStep(lfsr);
            tw = 8'(lfsr % words[m]);
            wr(ADDR_CTRL, 8'h11 | 8'(m << 1));
            wr(ADDR_TUNE, 8'hC0 | tw);
            rd(ADDR_CTRL);
            checkByte(rv, 8'h11 | 8'(m << 1), "mode code");
            rd(ADDR_TUNE);
            checkByte(rv, tw, "tune word");
            wr(ADDR_XFER, 8'h01);
            modePin <= m[0];
            settle();
            checkByte(8'(chanActive), 8'h0F, "pin ignored");
            sendSamples(4'hF, 6);
        end
        settle();
        checkByte(8'(noteQ.size()), 8'h00, "notes left");
        final_report();
    end
endmodule
